// ===== core/acw_pkg.sv
// Purpose: constants for the auto conversion window monitor
// Assumes: 40 MHz clk, 8-bit register port
// Notes:   register offsets are indices on the plain port
//
// Overview of operation
// - when the period counter reaches the chosen interval a conversion request goes out with no software help.
// - interval_select picks 4 ms for code 000, doubling per step, up to 512 ms for code 111.
// - a result outside the lower..upper window increments the 3-bit event counter by one.
// - when the event counter equals the threshold an interrupt is raised and the counter clears to zero.
// - event_threshold codes 00, 01, 10, 11 mean one, two, four and seven events.
// - auto_conv_enable in bit 7 of auto_conv_control runs the period counter; clearing it stops conversions.
// - the upper limit keeps bits 9..2 in upper_limit_high and bits 1..0 in bits 7..6 of upper_limit_low.
// - the lower limit uses the same split in lower_limit_high and lower_limit_low.
// - bits without a function read as zero and ignore writes.
// - turn_on_timing_disable in bit 5 of auto_conv_control: 0 enables turn-on timing, 1 disables it.
// - trigger, compare and counting keep running while the cpu sleeps so the interrupt can wake it.
// - the event counter in bits 6..4 of event_count_config is software readable and writable.
// - each conversion takes 14 converter clocks, 4 sampling and 10 converting, and the full 10-bit result is compared.
package acw_pkg;
    localparam int unsigned CLK_HZ          = 40_000_000;
    localparam int unsigned BASE_MS         = 4;
    localparam int unsigned BASE_CYC        = CLK_HZ / 1000 * BASE_MS;
    localparam int unsigned ADC_SAMPLE_CYC  = 4;
    localparam int unsigned ADC_CONV_CYC    = 10;
    localparam int unsigned ADC_TOTAL_CYC   = ADC_SAMPLE_CYC + ADC_CONV_CYC;
    localparam int unsigned CNT_W           = 32;

    localparam logic [3:0] OFS_CTRL     = 4'h0;
    localparam logic [3:0] OFS_EVCFG    = 4'h1;
    localparam logic [3:0] OFS_UL_LO    = 4'h2;
    localparam logic [3:0] OFS_UL_HI    = 4'h3;
    localparam logic [3:0] OFS_LL_LO    = 4'h4;
    localparam logic [3:0] OFS_LL_HI    = 4'h5;
    localparam logic [3:0] OFS_IRQ_STAT = 4'h6;
    localparam logic [3:0] OFS_IRQ_EN   = 4'h7;
    localparam logic [3:0] OFS_IRQ_CLR  = 4'h8;

    localparam int unsigned CTRL_EN_BIT  = 7;
    localparam int unsigned CTRL_TOD_BIT = 5;
    localparam int unsigned EVC_LSB      = 4;
    localparam int unsigned LO_LSB       = 6;
    localparam int unsigned IRQ_THR_BIT  = 0;
    localparam int unsigned IRQ_OUT_BIT  = 1;

    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] THR_1 = 3'h1;
    localparam logic [2:0] THR_2 = 3'h2;
    localparam logic [2:0] THR_4 = 3'h4;
    localparam logic [2:0] THR_7 = 3'h7;

    typedef enum logic [1:0] {
        ACW_IDLE = 2'b00,
        ACW_CONV = 2'b01,
        ACW_EVAL = 2'b10
    } acw_state_e;
endpackage

// ===== core/acw_monitor.sv
// Purpose: periodic auto conversion trigger with window compare and events
// Assumes: converter answers each start with a done pulse and a result
// Notes:   one clock domain; keeps running while the cpu sleeps
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module acw_monitor
    import acw_pkg::*;
#(
    parameter int unsigned BASE_CYCLES = BASE_CYC,
    parameter int unsigned CONV_CYCLES = ADC_TOTAL_CYC
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        clk_en,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    output logic             adc_power,
    output logic             adc_start,
    output logic             turn_on_timing_disable,
    input  wire logic        adc_done,
    input  wire logic [9:0]  adc_result,
    output logic             irq
);

    // ******************************************************
    // helpers
    // ******************************************************
    function automatic logic [CNT_W-1:0] period_cycles(input logic [2:0] sel);
        period_cycles = CNT_W'(BASE_CYCLES) << sel;
    endfunction

    function automatic logic [2:0] thr_count(input logic [1:0] code);
        case (code)
            2'b00:   thr_count = THR_1;
            2'b01:   thr_count = THR_2;
            2'b10:   thr_count = THR_4;
            default: thr_count = THR_7;
        endcase
    endfunction

    // ******************************************************
    // state
    // ******************************************************
    typedef struct packed {
        logic              en;
        logic              tod;
        logic [2:0]        interval_select;
        logic [2:0]        event_counter;
        logic [1:0]        event_threshold;
        logic [9:0]        upper;
        logic [9:0]        lower;
        logic [1:0]        irq_stat;
        logic [1:0]        irq_en;
        logic [CNT_W-1:0]  period;
        logic [CNT_W-1:0]  wdog;
        acw_state_e        st;
        logic [9:0]        result;
        logic              start;
        logic              power;
        logic [7:0]        rdata;
    } acw_s;

    acw_s s_q;
    acw_s s_d;

    logic outside;
    logic [2:0] ev_next;
    logic ev_hit;

    // ******************************************************
    // next state
    // ******************************************************
    always_comb begin
        s_d = s_q;
        s_d.start = 1'b0;
        s_d.rdata = RST_BYTE;
        outside = (adc_result > s_q.upper) || (adc_result < s_q.lower);
        ev_next = s_q.event_counter;
        ev_hit = 1'b0;

        // register writes
        if (reg_wr) begin
            case (reg_addr)
                OFS_CTRL: begin
                    s_d.en = reg_wdata[CTRL_EN_BIT];
                    s_d.tod = reg_wdata[CTRL_TOD_BIT];
                    s_d.interval_select = reg_wdata[2:0];
                end
                OFS_EVCFG: begin
                    s_d.event_counter = reg_wdata[EVC_LSB +: 3];
                    s_d.event_threshold = reg_wdata[1:0];
                end
                OFS_UL_LO: s_d.upper[1:0] = reg_wdata[LO_LSB +: 2];
                OFS_UL_HI: s_d.upper[9:2] = reg_wdata;
                OFS_LL_LO: s_d.lower[1:0] = reg_wdata[LO_LSB +: 2];
                OFS_LL_HI: s_d.lower[9:2] = reg_wdata;
                OFS_IRQ_EN: s_d.irq_en = reg_wdata[1:0];
                OFS_IRQ_CLR: s_d.irq_stat = s_q.irq_stat & ~reg_wdata[1:0];
                default: ;
            endcase
        end

        // reads: unused bits stay zero
        if (reg_rd) begin
            case (reg_addr)
                OFS_CTRL: begin
                    s_d.rdata[CTRL_EN_BIT] = s_q.en;
                    s_d.rdata[CTRL_TOD_BIT] = s_q.tod;
                    s_d.rdata[2:0] = s_q.interval_select;
                end
                OFS_EVCFG: begin
                    s_d.rdata[EVC_LSB +: 3] = s_q.event_counter;
                    s_d.rdata[1:0] = s_q.event_threshold;
                end
                OFS_UL_LO: s_d.rdata[LO_LSB +: 2] = s_q.upper[1:0];
                OFS_UL_HI: s_d.rdata = s_q.upper[9:2];
                OFS_LL_LO: s_d.rdata[LO_LSB +: 2] = s_q.lower[1:0];
                OFS_LL_HI: s_d.rdata = s_q.lower[9:2];
                OFS_IRQ_STAT: s_d.rdata[1:0] = s_q.irq_stat;
                OFS_IRQ_EN: s_d.rdata[1:0] = s_q.irq_en;
                default: s_d.rdata = RST_BYTE;
            endcase
        end

        // sequencer; no cpu input, so sleep does not stop it
        case (s_q.st)
            ACW_IDLE: begin
                s_d.power = 1'b0;
                if (!s_q.en) begin
                    s_d.period = '0;
                end else if (s_q.period + 1'b1 >= period_cycles(s_q.interval_select)) begin
                    s_d.period = '0;
                    s_d.start = 1'b1;
                    s_d.power = 1'b1;
                    s_d.wdog = '0;
                    s_d.st = ACW_CONV;
                end else begin
                    s_d.period = s_q.period + 1'b1;
                end
            end
            ACW_CONV: begin
                // period keeps counting so the interval stays exact
                s_d.period = s_q.period + 1'b1;
                s_d.wdog = s_q.wdog + 1'b1;
                if (adc_done) begin
                    s_d.result = adc_result;
                    s_d.st = ACW_EVAL;
                    if (outside) begin
                        ev_next = s_q.event_counter + 1'b1;
                    end
                    ev_hit = (ev_next == thr_count(s_q.event_threshold));
                    s_d.event_counter = ev_hit ? 3'h0 : ev_next;
                    s_d.power = 1'b0;
                end else if (!s_q.en) begin
                    s_d.st = ACW_IDLE;
                    s_d.power = 1'b0;
                end else if (s_q.wdog >=
                             period_cycles(s_q.interval_select)) begin
                    // a converter that never answers must not stall triggers
                    s_d.st = ACW_IDLE;
                    s_d.power = 1'b0;
                end
            end
            ACW_EVAL: begin
                s_d.period = s_q.period + 1'b1;
                s_d.st = ACW_IDLE;
            end
            default: s_d.st = ACW_IDLE;
        endcase

        // set wins over software clear
        if (ev_hit) begin
            s_d.irq_stat[IRQ_THR_BIT] = 1'b1;
        end
        if (adc_done && s_q.st == ACW_CONV && outside) begin
            s_d.irq_stat[IRQ_OUT_BIT] = 1'b1;
        end
    end

    // ******************************************************
    // registers
    // ******************************************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '{st: ACW_IDLE, default: '0};
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign adc_start = s_q.start;
    assign adc_power = s_q.power;
    assign turn_on_timing_disable = s_q.tod;
    assign irq = |(s_q.irq_stat & s_q.irq_en);

    // ******************************************************
    // checks
    // ******************************************************
    sequence s_trig;
        clk_en && adc_start;
    endsequence

    sequence s_done_taken;
        clk_en && s_q.st == ACW_CONV && adc_done;
    endsequence

    sequence s_eval_step;
        clk_en && s_q.st == ACW_EVAL;
    endsequence

    property p_trig_power;
        @(posedge clk) disable iff (!arst_n)
        s_trig |-> adc_power;
    endproperty
    a_trig_power: assert property (p_trig_power)
        else $error("converter not powered with start");

    property p_done_power_off;
        @(posedge clk) disable iff (!arst_n)
        s_done_taken |=> !adc_power && s_q.st == ACW_EVAL;
    endproperty
    a_done_power_off: assert property (p_done_power_off)
        else $error("converter still powered after done");

    property p_eval_back;
        @(posedge clk) disable iff (!arst_n)
        s_eval_step |=> s_q.st == ACW_IDLE;
    endproperty
    a_eval_back: assert property (p_eval_back)
        else $error("sequencer did not return to wait");

    property p_outside_count;
        @(posedge clk) disable iff (!arst_n)
        s_done_taken ##0 (outside && !ev_hit)
        |=> s_q.event_counter == $past(s_q.event_counter) + 3'h1;
    endproperty
    a_outside_count: assert property (p_outside_count)
        else $error("outside result did not count");

    property p_read_idle_zero;
        @(posedge clk) disable iff (!arst_n)
        clk_en && !reg_rd |=> reg_rdata == RST_BYTE;
    endproperty
    a_read_idle_zero: assert property (p_read_idle_zero)
        else $error("read data not zero outside a read");

    property p_ctrl_reserved;
        @(posedge clk) disable iff (!arst_n)
        clk_en && reg_rd && reg_addr == OFS_CTRL
        |=> reg_rdata[6] == 1'b0 && reg_rdata[4:3] == 2'b00;
    endproperty
    a_ctrl_reserved: assert property (p_ctrl_reserved)
        else $error("control reserved bits nonzero");

    property p_evcfg_reserved;
        @(posedge clk) disable iff (!arst_n)
        clk_en && reg_rd && reg_addr == OFS_EVCFG
        |=> reg_rdata[7] == 1'b0 && reg_rdata[3:2] == 2'b00;
    endproperty
    a_evcfg_reserved: assert property (p_evcfg_reserved)
        else $error("event config reserved bits nonzero");

    property p_disabled_quiet;
        @(posedge clk) disable iff (!arst_n)
        clk_en && !s_q.en && s_q.st == ACW_IDLE |=> !adc_start;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet)
        else $error("start while function disabled");

    property p_stat_sticky;
        @(posedge clk) disable iff (!arst_n)
        clk_en && s_q.irq_stat[IRQ_THR_BIT]
        && !(reg_wr && reg_addr == OFS_IRQ_CLR)
        |=> s_q.irq_stat[IRQ_THR_BIT];
    endproperty
    a_stat_sticky: assert property (p_stat_sticky)
        else $error("threshold status lost without clear");

    property p_lower_high;
        @(posedge clk) disable iff (!arst_n)
        clk_en && reg_wr && reg_addr == OFS_LL_HI
        |=> s_q.lower[9:2] == $past(reg_wdata);
    endproperty
    a_lower_high: assert property (p_lower_high)
        else $error("lower limit high byte not stored");

    property p_upper_low;
        @(posedge clk) disable iff (!arst_n)
        clk_en && reg_wr && reg_addr == OFS_UL_LO
        |=> s_q.upper[1:0] == $past(reg_wdata[7:6]);
    endproperty
    a_upper_low: assert property (p_upper_low)
        else $error("upper limit low bits not stored");

    property p_freeze;
        @(posedge clk) disable iff (!arst_n)
        !clk_en |=> $stable(s_q);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved while clock enable low");

    property p_start_rearms;
        @(posedge clk) disable iff (!arst_n)
        adc_start |-> (s_q.period == '0) && (s_q.st == ACW_CONV);
    endproperty
    a_start_rearms: assert property (p_start_rearms)
        else $error("period not restarted on trigger");

    property p_no_start_disabled;
        @(posedge clk) disable iff (!arst_n)
        $rose(adc_start) |-> $past(s_q.en);
    endproperty
    a_no_start_disabled: assert property (p_no_start_disabled)
        else $error("trigger while disabled");

    property p_start_pulse;
        @(posedge clk) disable iff (!arst_n)
        adc_start && clk_en |=> !adc_start;
    endproperty
    a_start_pulse: assert property (p_start_pulse)
        else $error("start longer than one cycle");

    property p_hit_clears;
        @(posedge clk) disable iff (!arst_n)
        clk_en && ev_hit |=> s_q.event_counter == 3'h0 && s_q.irq_stat[IRQ_THR_BIT];
    endproperty
    a_hit_clears: assert property (p_hit_clears)
        else $error("event threshold did not clear counter");

    property p_inside_holds;
        @(posedge clk) disable iff (!arst_n)
        clk_en && !reg_wr && s_q.st == ACW_CONV && adc_done && !outside
        |=> s_q.event_counter == $past(s_q.event_counter)
            || s_q.event_counter == 3'h0;
    endproperty
    a_inside_holds: assert property (p_inside_holds)
        else $error("inside result changed event count");

    property p_irq_level;
        @(posedge clk) disable iff (!arst_n)
        clk_en && ev_hit && s_q.irq_en[IRQ_THR_BIT] |=> irq;
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("enabled threshold event raised no irq");

    property p_reserved_zero;
        @(posedge clk) disable iff (!arst_n)
        clk_en && reg_rd && reg_addr == OFS_UL_LO |=> reg_rdata[5:0] == 6'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits read nonzero");

    property p_upper_split;
        @(posedge clk) disable iff (!arst_n)
        clk_en && reg_wr && reg_addr == OFS_UL_HI |=> s_q.upper[9:2] == $past(reg_wdata);
    endproperty
    a_upper_split: assert property (p_upper_split)
        else $error("upper limit high byte not stored");

    property p_lower_split;
        @(posedge clk) disable iff (!arst_n)
        clk_en && reg_wr && reg_addr == OFS_LL_LO |=> s_q.lower[1:0] == $past(reg_wdata[7:6]);
    endproperty
    a_lower_split: assert property (p_lower_split)
        else $error("lower limit low bits not stored");

    property p_evc_write;
        @(posedge clk) disable iff (!arst_n)
        clk_en && reg_wr && reg_addr == OFS_EVCFG && s_q.st != ACW_CONV
        |=> s_q.event_counter == $past(reg_wdata[6:4]);
    endproperty
    a_evc_write: assert property (p_evc_write)
        else $error("event counter write lost");

    property p_tod_out;
        @(posedge clk) disable iff (!arst_n)
        clk_en && reg_wr && reg_addr == OFS_CTRL |=> turn_on_timing_disable == $past(reg_wdata[5]);
    endproperty
    a_tod_out: assert property (p_tod_out)
        else $error("turn-on timing bit not applied");
endmodule
`default_nettype wire

// ===== bench/acw_adc_model.sv
// Purpose: behavioural converter answering each start request
// Assumes: start is a one-cycle pulse, result supplied by the bench
// Notes:   result is scrambled outside the done cycle
`timescale 1ns/1ps
`default_nettype none
module acw_adc_model #(
    parameter int DLY = 14
) (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       adc_start,
    input  wire logic [9:0] res_in,
    output logic            adc_done,
    output logic [9:0]      adc_result
);
    int cnt;
    // stale data changes every cycle so nobody can rely on it
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt        <= 0;
            adc_done   <= 1'b0;
            adc_result <= 10'h000;
        end else begin
            adc_done   <= (cnt == 1);
            adc_result <= (cnt == 1) ? res_in : ~adc_result;
            if (adc_start)
                cnt <= DLY;
            else if (cnt != 0)
                cnt <= cnt - 1;
        end
    end
endmodule
`default_nettype wire

// ===== bench/acw_monitor_tb.sv
// Purpose: self-checking bench for the auto conversion window monitor
// Assumes: base period shortened to 32 cycles
// Notes:   window 101..202, so 100 and 203 are the first outside codes
`timescale 1ns/1ps
`default_nettype none
module acw_monitor_tb;
    import acw_pkg::*;
    localparam int BASE = 32;
    localparam logic [7:0] MSK [6] = '{8'h27, 8'h73, 8'hC0, 8'hFF, 8'hC0, 8'hFF};
    localparam int NEV [4] = '{1, 2, 4, 7};
    logic       clk, arst_n, clk_en, reg_wr, reg_rd;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic       adc_power, adc_start, tod, adc_done, irq;
    logic [9:0] adc_result, m_res;
    logic [31:0] x;
    int         error_cnt = 0;
    int         tests_run = 0;
    int         nst = 0;

    acw_monitor #(.BASE_CYCLES(BASE)) dut (.clk(clk), .arst_n(arst_n),
        .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .adc_power(adc_power), .adc_start(adc_start),
        .turn_on_timing_disable(tod), .adc_done(adc_done),
        .adc_result(adc_result), .irq(irq));
    acw_adc_model mdl (.clk(clk), .arst_n(arst_n), .adc_start(adc_start),
        .res_in(m_res), .adc_done(adc_done), .adc_result(adc_result));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) if (adc_start === 1'b1) nst <= nst + 1;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] xs();
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        tests_run++;
        if (s !== e) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wr(input int a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= 4'(a);
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        #1;
    endtask
    task automatic rd(input int a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= 4'(a);
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // bounded wait for a start pulse (st=1) or a done pulse (st=0)
    task automatic wt(input bit st, output int n);
        for (n = 1; n < 5000; n++) begin
            @(posedge clk);
            #1;
            if ((st ? adc_start : adc_done) === 1'b1) break;
        end
        if (n == 5000) chk(0, 1);
    endtask
    task automatic conv(input logic [9:0] v, input int ev, input int th,
                        input logic iq);
        logic [7:0] d;
        int         n;
        m_res <= v;
        wt(0, n);
        chk(adc_power, 1);
        @(posedge clk);
        #1;
        chk(adc_power, 0);
        m_res <= 10'h096;
        rd(OFS_EVCFG, d);
        chk(d, {1'b0, 3'(ev), 2'b00, 2'(th)});
        chk(irq, iq);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        int a, c, k, n;
        logic [7:0] d;
        logic [31:0] r;
        logic [9:0] v;
        x = 32'hA6BAF078;
        {arst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        clk_en = 1'b1;
        m_res = 10'h096;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        for (a = 0; a < 6; a++) begin
            rd(a, d);
            chk(d, 0);
            wr(a, a == 0 ? 8'h7F : 8'hFF);
            rd(a, d);
            chk(d, MSK[a]);
        end
        chk(tod, 1);
        wr(9, 8'hFF);
        rd(9, d);
        chk(d, 0);
        wr(OFS_CTRL, 8'h00);
        chk(tod, 0);
        wr(OFS_EVCFG, 8'h00);
        wr(OFS_UL_LO, 8'h80);
        wr(OFS_UL_HI, 8'h32);
        wr(OFS_LL_LO, 8'h40);
        wr(OFS_LL_HI, 8'h19);
        for (a = 0; a < 8; a = (a == 2) ? 7 : a + 1) begin
            wr(OFS_CTRL, 8'h80 | 8'(a));
            wt(1, n);
            wt(1, n);
            chk(n, BASE << a);
        end
        wr(OFS_CTRL, 8'h00);
        a = nst;
        repeat (300) @(posedge clk);
        chk(nst - a, 0);
        // a frozen block must ignore the write strobe
        @(posedge clk);
        clk_en <= 1'b0;
        wr(OFS_UL_HI, 8'h55);
        clk_en <= 1'b1;
        rd(OFS_UL_HI, d);
        chk(d, 8'h32);
        for (c = 0; c < 4; c++) begin
            wr(OFS_CTRL, 8'h00);
            repeat (20) @(posedge clk);
            wr(OFS_EVCFG, 8'(c));
            wr(OFS_IRQ_EN, {7'h00, c != 0});
            wr(OFS_CTRL, 8'h80);
            for (k = 1; k <= NEV[c]; k++) begin
                r = xs();
                v = r[0] ? 10'(r[9:1] % 101) : 10'(203 + r[31:10] % 821);
                conv(k[0] ? 10'h065 : 10'h0CA, k - 1, c, 1'b0);
                conv(k == 1 ? 10'h064 : (k == 2 ? 10'h0CB : v), k % NEV[c],
                     c, k == NEV[c] && c != 0);
            end
            // masked event: status holds, irq waits for the enable
            if (c == 0) begin
                rd(OFS_IRQ_STAT, d);
                chk(d[0], 1);
                wr(OFS_IRQ_EN, 8'h01);
                chk(irq, 1);
            end
            wr(OFS_IRQ_CLR, 8'h01);
            chk(irq, 0);
        end
        stop_test();
    end
    initial begin
        #1500000;
        error_cnt++;
        stop_test();
    end
endmodule
`default_nettype wire
